// File: hbc_cfg.svh
// constants of the holding brake interlock: register offsets, field positions,
// reset values, limits and timing figures; definitions only
`ifndef HBC_CFG_SVH
`define HBC_CFG_SVH

// register offsets on the plain register port
`define HBC_A_ROUTE 4'h0
`define HBC_A_DELAY 4'h1
`define HBC_A_SPEED 4'h2
`define HBC_A_WAIT 4'h3
`define HBC_A_ROT 4'h4
`define HBC_A_STATUS 4'h5

// route register fields
`define HBC_F_BRK_LSB 0
`define HBC_F_TG_LSB 4

// reset values
`define HBC_ROUTE_RST 16'h0000
`define HBC_DELAY_RST 16'h0000
`define HBC_SPEED_RST 16'h0064
`define HBC_WAIT_RST 16'h0032
`define HBC_ROT_RST 16'h0014

// accepted ranges of written values
`define HBC_ROUTE_MAX 4'h6
`define HBC_DELAY_MAX 16'h01f4
`define HBC_SPEED_MAX 16'h1770
`define HBC_WAIT_MIN 16'h000a
`define HBC_WAIT_MAX 16'h0064

// timing: one delay unit in ms and the clock period in ns
`define HBC_UNIT_MS 10
`define HBC_CLK_NS 10
`define HBC_UNIT_CYCLES ((`HBC_UNIT_MS * 1000000) / `HBC_CLK_NS)

`endif

// File: hbc_pkg.sv
// types of the holding brake interlock
// assumes hbc_cfg.svh supplies the numeric constants
package hbc_pkg;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } hbc_bus_req_t;

   typedef enum logic [3:0] {
      HBC_OFF = 4'b0001,
      HBC_ON = 4'b0010,
      HBC_STOP_DLY = 4'b0100,
      HBC_RUN_DN = 4'b1000
   } hbc_state_t;

endpackage

// File: hbc_brake.sv
// holding brake interlock: brake release output, routing onto six output
// terminals, servo-off and alarm sequencing of brake against motor power
// assumes one 100 MHz clock, inputs synchronous to it, signed speed in r/min
`timescale 1ns/1ps
`include "hbc_cfg.svh"

module hbc_brake #(
   parameter int UNIT_CYCLES = `HBC_UNIT_CYCLES
) (
   input wire logic clk, // 100 MHz clock
   input wire logic resetn, // async reset, active low
   input wire hbc_pkg::hbc_bus_req_t bus_req, // register request
   output logic [15:0] rdata, // read data, cycle after rd
   input wire logic servo_on, // servo-on request, level
   input wire logic alarm, // drive alarm, level
   input wire logic signed [15:0] motor_speed, // speed in r/min
   input wire logic [5:0] ext_out_on, // other functions asserted per terminal
   output logic motor_energize, // motor power enabled
   output logic brake_release_n, // low releases the brake
   output logic motion_detect_n, // low while rotating
   output logic output_terminal_one, // terminal 1, low is on
   output logic output_terminal_two, // terminal 2, low is on
   output logic output_terminal_three, // terminal 3, low is on
   output logic output_terminal_four, // terminal 4, low is on
   output logic output_terminal_five, // terminal 5, low is on
   output logic output_terminal_six // terminal 6, low is on
);
   import hbc_pkg::*;

   localparam int UW = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;

   if (UNIT_CYCLES < 1) begin : g_chk
      $error("UNIT_CYCLES must be at least one");
   end

   function automatic logic [15:0] speed_mag(input logic signed [15:0] s);
      speed_mag = s[15] ? 16'(-s) : 16'(s);
   endfunction

   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction

   // registers
   logic [3:0] brk_route_ff, nxt_brk_route;
   logic [3:0] tg_route_ff, nxt_tg_route;
   logic [15:0] delay_ff, nxt_delay;
   logic [15:0] speed_ff, nxt_speed;
   logic [15:0] wait_ff, nxt_wait;
   logic [15:0] rot_ff, nxt_rot;
   logic [15:0] rdata_ff, nxt_rdata;

   // sequencer
   hbc_state_t state_ff, nxt_state;
   logic [UW-1:0] unit_cnt_ff, nxt_unit_cnt;
   logic [15:0] tick_cnt_ff, nxt_tick_cnt;
   logic energize_ff, nxt_energize;
   logic brake_n_ff, nxt_brake_n;
   logic motion_n_ff, nxt_motion_n;
   logic [5:0] term_n_ff, nxt_term_n;

   logic [15:0] mag;
   logic rotating;
   logic tick;
   logic stop_req;

   assign mag = speed_mag(motor_speed);
   assign rotating = (mag >= rot_ff);
   assign tick = (unit_cnt_ff == UW'(UNIT_CYCLES - 1));
   assign stop_req = alarm || !servo_on;

   // register file
   always_comb begin
      nxt_brk_route = brk_route_ff;
      nxt_tg_route = tg_route_ff;
      nxt_delay = delay_ff;
      nxt_speed = speed_ff;
      nxt_wait = wait_ff;
      nxt_rot = rot_ff;
      nxt_rdata = 16'h0000;
      if (bus_req.wr) begin
         unique case (bus_req.addr)
            `HBC_A_ROUTE: begin
               if (bus_req.wdata[`HBC_F_BRK_LSB+:4] <= `HBC_ROUTE_MAX) begin
                  nxt_brk_route = bus_req.wdata[`HBC_F_BRK_LSB+:4];
               end
               if (bus_req.wdata[`HBC_F_TG_LSB+:4] <= `HBC_ROUTE_MAX) begin
                  nxt_tg_route = bus_req.wdata[`HBC_F_TG_LSB+:4];
               end
            end
            `HBC_A_DELAY: begin
               if (in_range(bus_req.wdata, 16'h0000, `HBC_DELAY_MAX)) begin
                  nxt_delay = bus_req.wdata;
               end
            end
            `HBC_A_SPEED: begin
               if (in_range(bus_req.wdata, 16'h0000, `HBC_SPEED_MAX)) begin
                  nxt_speed = bus_req.wdata;
               end
            end
            `HBC_A_WAIT: begin
               if (in_range(bus_req.wdata, `HBC_WAIT_MIN, `HBC_WAIT_MAX)) begin
                  nxt_wait = bus_req.wdata;
               end
            end
            `HBC_A_ROT: begin
               nxt_rot = bus_req.wdata;
            end
            default: begin
            end
         endcase
      end
      if (bus_req.rd) begin
         unique case (bus_req.addr)
            `HBC_A_ROUTE: nxt_rdata = {8'h00, tg_route_ff, brk_route_ff};
            `HBC_A_DELAY: nxt_rdata = delay_ff;
            `HBC_A_SPEED: nxt_rdata = speed_ff;
            `HBC_A_WAIT: nxt_rdata = wait_ff;
            `HBC_A_ROT: nxt_rdata = rot_ff;
            `HBC_A_STATUS: nxt_rdata = {9'h000, motion_n_ff, brake_n_ff, energize_ff,
                                        state_ff};
            default: nxt_rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         brk_route_ff <= 4'(`HBC_ROUTE_RST);
         tg_route_ff <= 4'(`HBC_ROUTE_RST >> `HBC_F_TG_LSB);
         delay_ff <= `HBC_DELAY_RST;
         speed_ff <= `HBC_SPEED_RST;
         wait_ff <= `HBC_WAIT_RST;
         rot_ff <= `HBC_ROT_RST;
         rdata_ff <= 16'h0000;
      end else begin
         brk_route_ff <= nxt_brk_route;
         tg_route_ff <= nxt_tg_route;
         delay_ff <= nxt_delay;
         speed_ff <= nxt_speed;
         wait_ff <= nxt_wait;
         rot_ff <= nxt_rot;
         rdata_ff <= nxt_rdata;
      end
   end

   // sequencer: state, 10 ms prescaler and unit counter
   always_comb begin
      nxt_state = state_ff;
      nxt_unit_cnt = tick ? '0 : unit_cnt_ff + UW'(1);
      nxt_tick_cnt = tick ? tick_cnt_ff + 16'h0001 : tick_cnt_ff;
      unique case (state_ff)
         HBC_OFF: begin
            if (!stop_req) begin
               nxt_state = HBC_ON;
            end
         end
         HBC_ON: begin
            if (stop_req) begin
               if (rotating) begin
                  nxt_state = HBC_RUN_DN;
               end else if (alarm || delay_ff == 16'h0000) begin
                  nxt_state = HBC_OFF;
               end else begin
                  nxt_state = HBC_STOP_DLY;
               end
            end
         end
         HBC_STOP_DLY: begin
            if (alarm) begin
               nxt_state = HBC_OFF;
            end else if (servo_on) begin
               nxt_state = HBC_ON;
            end else if (tick && nxt_tick_cnt >= delay_ff) begin
               nxt_state = HBC_OFF;
            end
         end
         HBC_RUN_DN: begin
            if (mag < speed_ff) begin
               nxt_state = HBC_OFF;
            end else if (tick && nxt_tick_cnt >= wait_ff) begin
               nxt_state = HBC_OFF;
            end
         end
      endcase
      if (nxt_state != state_ff) begin
         nxt_unit_cnt = '0;
         nxt_tick_cnt = 16'h0000;
      end
      nxt_energize = (nxt_state == HBC_ON) || (nxt_state == HBC_STOP_DLY);
      // brake released only while powered on or coasting down
      nxt_brake_n = !((nxt_state == HBC_ON) || (nxt_state == HBC_RUN_DN));
      nxt_motion_n = !rotating;
      for (int k = 0; k < 6; k++) begin
         nxt_term_n[k] = !(((brk_route_ff == 4'(k + 1)) && !brake_n_ff)
                           || ((tg_route_ff == 4'(k + 1)) && !motion_n_ff)
                           || ext_out_on[k]);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= HBC_OFF;
         unit_cnt_ff <= '0;
         tick_cnt_ff <= 16'h0000;
         energize_ff <= 1'b0;
         brake_n_ff <= 1'b1;
         motion_n_ff <= 1'b1;
         term_n_ff <= 6'h3f;
      end else begin
         state_ff <= nxt_state;
         unit_cnt_ff <= nxt_unit_cnt;
         tick_cnt_ff <= nxt_tick_cnt;
         energize_ff <= nxt_energize;
         brake_n_ff <= nxt_brake_n;
         motion_n_ff <= nxt_motion_n;
         term_n_ff <= nxt_term_n;
      end
   end

   assign rdata = rdata_ff;
   assign motor_energize = energize_ff;
   assign brake_release_n = brake_n_ff;
   assign motion_detect_n = motion_n_ff;
   assign output_terminal_one = term_n_ff[0];
   assign output_terminal_two = term_n_ff[1];
   assign output_terminal_three = term_n_ff[2];
   assign output_terminal_four = term_n_ff[3];
   assign output_terminal_five = term_n_ff[4];
   assign output_terminal_six = term_n_ff[5];

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_stop_still;
      state_ff == HBC_ON && !alarm && !servo_on && !rotating && delay_ff != 16'h0000;
   endsequence

   sequence s_stop_moving;
      state_ff == HBC_ON && stop_req && rotating;
   endsequence

   a_brake_active_low: assert property (
      state_ff == HBC_ON |-> !brake_release_n && motor_energize)
      else $error("brake not released while servo on");

   a_route_none: assert property (
      brk_route_ff == 4'h0 && tg_route_ff == 4'h0 && ext_out_on == 6'h00
      |=> term_n_ff == 6'h3f)
      else $error("terminal active with nothing routed");

   a_route_select: assert property (
      brk_route_ff == 4'h3 && !brake_n_ff |=> !output_terminal_three)
      else $error("brake release not on selected terminal");

   a_or_merge: assert property (
      ext_out_on[5] |=> !output_terminal_six)
      else $error("terminal six misses an assigned function");

   a_stop_delay: assert property (
      s_stop_still |=> brake_release_n && motor_energize && state_ff == HBC_STOP_DLY)
      else $error("stopped servo off did not hold brake with power on");

   a_alarm_cut: assert property (
      (state_ff == HBC_ON || state_ff == HBC_STOP_DLY) && alarm && !rotating
      |=> !motor_energize ##0 brake_release_n)
      else $error("alarm did not cut motor power at once");

   a_speed_level: assert property (
      state_ff == HBC_RUN_DN && mag < speed_ff |=> brake_release_n)
      else $error("brake not held below speed threshold");

   a_wait_expire: assert property (
      state_ff == HBC_RUN_DN && tick && tick_cnt_ff + 16'h0001 >= wait_ff
      |=> brake_release_n)
      else $error("brake not held after wait time");

   a_run_down: assert property (
      s_stop_moving |=> state_ff == HBC_RUN_DN && !motor_energize && !brake_release_n)
      else $error("rotating stop did not coast with brake released");

   a_speed_sign: assert property (
      state_ff == HBC_RUN_DN && motor_speed[15] && 16'(-motor_speed) < speed_ff
      |=> state_ff == HBC_OFF)
      else $error("reverse speed not compared by magnitude");

endmodule

// File: hbc_relay.sv
// behavioural brake relay hanging on one output terminal of the drive
// assumes the terminal is low while the relay coil should pull in
`timescale 1ns/1ps

module hbc_relay #(
   parameter int DLY = 2
) (
   input wire logic clk, // system clock
   input wire logic coil_n, // terminal driving the coil, low pulls in
   output logic brake_held // high while the brake grips the shaft
);
   logic [7:0] pull_ff = 8'hff;

   // the relay contacts follow the coil a few cycles late
   always @(posedge clk) begin
      pull_ff <= {pull_ff[6:0], coil_n};
   end
   assign brake_held = pull_ff[DLY-1];
endmodule

// File: tb_hbc_brake.sv
// self-checking bench of the holding brake interlock
// assumes hbc_brake with a short delay unit and a relay on terminal three
`timescale 1ns/1ps
`include "hbc_cfg.svh"

module tb_hbc_brake;
   import hbc_pkg::*;
   localparam int U = 4;
   logic clk, resetn, servo_on, alarm, brake_release_n, motor_energize, held, motion_detect_n;
   logic signed [15:0] motor_speed;
   logic [5:0] ext_out_on, msk;
   wire [5:0] tv;
   logic [15:0] rdata;
   hbc_bus_req_t req;
   int n_fail, check_count, n, k;
   int cyc = 0;

   hbc_brake #(.UNIT_CYCLES(U)) u_dut (
      .clk(clk), .resetn(resetn), .bus_req(req), .rdata(rdata),
      .servo_on(servo_on), .alarm(alarm), .motor_speed(motor_speed),
      .ext_out_on(ext_out_on), .motor_energize(motor_energize),
      .brake_release_n(brake_release_n), .motion_detect_n(motion_detect_n),
      .output_terminal_one(tv[0]), .output_terminal_two(tv[1]),
      .output_terminal_three(tv[2]), .output_terminal_four(tv[3]),
      .output_terminal_five(tv[4]), .output_terminal_six(tv[5])
   );

   hbc_relay #(.DLY(2)) u_relay (.clk(clk), .coil_n(tv[2]), .brake_held(held));

   task automatic end_sim;
      if (n_fail == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask

   // counts cycles until brake (bk=1) or motor power reaches level v
   task automatic wt(input logic bk, input logic v, input int lim);
      n = 0;
      while ((bk ? brake_release_n : motor_energize) !== v && n < lim) begin
         @(posedge clk);
         #1 n++;
      end
   endtask

   task automatic go_on(input logic signed [15:0] s);
      @(posedge clk);
      servo_on <= 1'b1;
      alarm <= 1'b0;
      motor_speed <= s;
      repeat (4) @(posedge clk);
      #1;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc > 5000) begin
         n_fail++;
         end_sim();
      end
   end

   initial begin
      void'($urandom(32'h06101d30));
      resetn = 1'b0;
      servo_on = 1'b0;
      alarm = 1'b0;
      motor_speed = 16'sd0;
      ext_out_on = 6'h0;
      req = '0;
      n_fail = 0;
      check_count = 0;
      repeat (8) @(posedge clk);
      #1 chk("power and brake in reset", 16'h1, 16'({motor_energize, brake_release_n}));
      chk("terminals in reset", 16'h3f, 16'(tv));
      @(posedge clk) resetn <= 1'b1;
      rd(`HBC_A_ROUTE, 16'h0);
      rd(`HBC_A_DELAY, 16'h0);
      rd(`HBC_A_SPEED, 16'h64);
      rd(`HBC_A_WAIT, 16'h32);
      rd(`HBC_A_ROT, 16'h0014);
      rd(`HBC_A_STATUS, 16'h0061);
      rd(4'hf, 16'h0);
      wr(`HBC_A_ROUTE, 16'h7);
      rd(`HBC_A_ROUTE, 16'h0);
      go_on(16'sd0);
      chk("motion detect idle", 16'h1, 16'(motion_detect_n));
      for (k = 0; k <= 6; k++) begin
         // motion detect stays on no terminal, apart from the brake
         wr(`HBC_A_ROUTE, 16'(k));
         @(posedge clk) ext_out_on <= 6'($urandom);
         repeat (3) @(posedge clk);
         msk = (k == 0) ? 6'h0 : 6'h1 << (k - 1);
         #1 chk("brake released", 16'h0, 16'(brake_release_n));
         chk("terminals", {10'h0, ~(ext_out_on | msk)}, tv);
      end
      wr(`HBC_A_ROUTE, 16'h3);
      wr(`HBC_A_DELAY, 16'h2);
      @(posedge clk) ext_out_on <= 6'h0;
      repeat (4) @(posedge clk);
      #1 chk("relay released", 16'h0, 16'(held));
      @(posedge clk) servo_on <= 1'b0;
      wt(1, 1, 10);
      chk("brake hold time", 16'h1, 16'(n <= 2));
      chk("powered while held", 16'h1, 16'(motor_energize));
      wt(0, 0, 40);
      chk("power cut delay", 16'h1, 16'(n >= 2 * U - 2 && n <= 2 * U + 2));
      repeat (4) @(posedge clk);
      #1 chk("relay holds", 16'h1, 16'(held));
      go_on(16'sd0);
      @(posedge clk) alarm <= 1'b1;
      wt(0, 0, 10);
      chk("alarm cut", 16'h1, 16'(n <= 2));
      wr(`HBC_A_WAIT, 16'h000a);
      // motion detect on terminal five, apart from the brake on three
      wr(`HBC_A_ROUTE, 16'h0053);
      go_on(-16'(200 + $urandom % 5800));
      chk("motion detect", 16'h0, 16'(motion_detect_n));
      chk("terminal five", 16'h0, 16'(tv[4]));
      @(posedge clk) servo_on <= 1'b0;
      repeat (6) @(posedge clk);
      #1 chk("running down", 16'h0, 16'(brake_release_n));
      @(posedge clk) motor_speed <= -16'sd99;
      wt(1, 1, 10);
      chk("below threshold", 16'h1, 16'(n <= 3));
      for (k = 0; k < 2; k++) begin
         go_on(16'(200 + $urandom % 5800));
         @(posedge clk);
         if (k == 0) begin
            servo_on <= 1'b0;
         end else begin
            alarm <= 1'b1;
         end
         wt(1, 1, 100);
         chk("wait elapsed", 16'h1, 16'(n >= 10 * U - 2 && n <= 10 * U + 3));
      end
      end_sim();
   end
endmodule
